// ---- common/dwss_map.vh ----
`ifndef DWSS_MAP_VH
`define DWSS_MAP_VH
// Command codes
`define DWSS_CMD_WRITE 4'h0
`define DWSS_CMD_READ 4'h1
`define DWSS_CMD_MS_RD 4'h2
`define DWSS_CMD_MS_WR 4'h3
`define DWSS_CMD_FLUSH 4'h4
`define DWSS_CMD_NV_ADDR 4'h5
`define DWSS_CMD_NV_WR 4'h6
`define DWSS_CMD_NV_RD 4'h7
`define DWSS_CMD_USB_ST 4'h8
`define DWSS_CMD_FIRST_RSV 4'h9
// Command byte positions
`define DWSS_POS_C3 0
`define DWSS_POS_C2 3
`define DWSS_POS_C1 5
`define DWSS_POS_C0 6
// Width codes: log2 of bus width
`define DWSS_W1 2'h0
`define DWSS_W2 2'h1
`define DWSS_W4 2'h2
`define DWSS_W8 2'h3
// Ack levels on the output line
`define DWSS_ACK 1'h0
`define DWSS_NAK 1'h1
// Reset values
`define DWSS_BYTE_RST 8'h00
`define DWSS_NV_ADDR_RST 8'h00
`define DWSS_LINES_IDLE 8'hFF
`endif

// ---- hw/dwss_shift.v ----
`timescale 1ns/100ps
`include "dwss_map.vh"
// Byte shifter for 1/2/4/8-bit lanes with bit order select
module dwss_shift (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Control
    input wire load,
    input wire [7:0] load_byte,
    input wire sample,
    input wire advance,
    input wire [1:0] width,
    input wire lsb_first,
    input wire [7:0] lines_in,
    // Results
    output reg [7:0] rx_byte,
    output reg [7:0] tx_lanes
);
    // Outgoing byte being emptied
    reg [7:0] tx_sr;

    // Bits per beat
    function [3:0] beat_bits;
        input [1:0] w;
        begin
            beat_bits = 4'h1 << w;
        end
    endfunction

    // Lanes of the next beat, lane 0 carries first bit in order
    function [7:0] lanes_of;
        input [7:0] b;
        input [1:0] w;
        input lsbf;
        integer i;
        reg [7:0] r;
        begin
            r = `DWSS_LINES_IDLE;
            for (i = 0; i < 8; i = i + 1) begin
                if (i < beat_bits(w)) begin
                    r[i] = lsbf ? b[i] : b[7 - i];
                end
            end
            lanes_of = r;
        end
    endfunction

    // Shift out after each beat
    always @(posedge mclk) begin
        if (rst) begin
            tx_sr <= `DWSS_BYTE_RST;
            tx_lanes <= `DWSS_LINES_IDLE;
        end else if (load) begin
            tx_sr <= load_byte;
            tx_lanes <= lanes_of(load_byte, width, lsb_first);
        end else if (advance) begin
            tx_sr <= lsb_first ? (tx_sr >> beat_bits(width)) : (tx_sr << beat_bits(width));
            tx_lanes <= lanes_of(lsb_first ? (tx_sr >> beat_bits(width))
                : (tx_sr << beat_bits(width)), width, lsb_first);
        end
    end

    // Gather incoming lanes
    always @(posedge mclk) begin
        if (rst) begin
            rx_byte <= `DWSS_BYTE_RST;
        end else if (sample) begin
            case (width)
                `DWSS_W8: rx_byte <= lsb_first ? lines_in
                    : {lines_in[0], lines_in[1], lines_in[2], lines_in[3],
                       lines_in[4], lines_in[5], lines_in[6], lines_in[7]};
                `DWSS_W4: rx_byte <= lsb_first ? {lines_in[3:0], rx_byte[7:4]}
                    : {rx_byte[3:0], lines_in[0], lines_in[1], lines_in[2], lines_in[3]};
                `DWSS_W2: rx_byte <= lsb_first ? {lines_in[1:0], rx_byte[7:2]}
                    : {rx_byte[5:0], lines_in[0], lines_in[1]};
                default: rx_byte <= lsb_first ? {lines_in[0], rx_byte[7:1]}
                    : {rx_byte[6:0], lines_in[0]};
            endcase
        end
    end
endmodule

// ---- hw/dwss_slave.v ----
`timescale 1ns/100ps
`include "dwss_map.vh"

// Summary of operation
// R1 - Decode 4-bit command; 0 write, 1 read
// R2 - Codes 9 to 15 do nothing
// R3 - Command 2 returns RTS and DTR
// R4 - Command 3 sets DCD, RI, DSR, CTS
// R5 - Command 4 pulses flush to upstream buffers
// R6 - Command 5 captures memory address
// R7 - Command 6 writes memory at address
// R8 - Command 7 returns memory at address
// R9 - Command 8 returns 2-bit USB state
// R10 - Bit order from configuration memory
// R11 - Phase 1 only: modes 1 and 3
// R12 - Polarity sets idle clock level
// R13 - Master uses same polarity and phase
// R14 - Odd edges drive data bits
// R15 - Even edges sample data bits
// R16 - Idle drives status; master drives after edge 1
// R17 - Works without knowing clock rate
// R18 - Width from first edge line levels
// R19 - Ack or nak per data byte
// R20 - Idle lines show write space, read data
// R21 - Command bits at positions 0,3,5,6
// R22 - Polarity and order latched between transfers
module dwss_slave (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Link pins
    input wire sclk,
    input wire cs_n,
    input wire [7:0] bidir_data_lines_in,
    output reg [7:0] bidir_data_lines_out,
    output reg [7:0] bidir_data_lines_oe,
    output reg miso,
    // Configuration from nonvolatile_config_memory
    input wire cfg_cpol,
    input wire cfg_lsb_first,
    // Receive path (bytes to master)
    input wire rd_valid,
    input wire [7:0] rd_data,
    output reg rd_pop,
    // Transmit path (bytes from master)
    input wire wr_space,
    output reg wr_push,
    output reg [7:0] wr_data,
    // Modem emulation
    input wire modem_rts,
    input wire modem_dtr,
    output reg [3:0] modem_status,
    // Flush request
    output reg flush_req,
    // Nonvolatile memory access
    output reg [7:0] nv_addr,
    output reg nv_we,
    output reg [7:0] nv_wdata,
    input wire [7:0] nv_rdata,
    // USB state
    input wire [1:0] usb_state
);
    // States
    localparam ST_IDLE = 4'b0001;
    localparam ST_CMD = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_DONE = 4'b1000;

    // Synchronised pins
    wire [9:0] pins_s;
    wire sclk_s = pins_s[9];
    wire cs_n_s = pins_s[8];
    wire [7:0] lines_s = pins_s[7:0];

    // Latched configuration, sequencer state and shifter controls
    reg cpol;
    reg lsb_first;
    reg sclk_d;
    reg [3:0] state;
    reg [1:0] width;
    reg [3:0] cmd;
    reg edge_odd;
    reg [3:0] beats;
    reg [7:0] load_byte;
    reg load;
    reg sample;
    reg advance;
    wire [7:0] rx_byte;
    wire [7:0] tx_lanes;

    // Edge detection on synced clock
    wire any_edge = (sclk_s != sclk_d);
    // Leading edge leaves idle level
    wire lead_edge = any_edge & (sclk_d == cpol); // R12

    // Command decoding helpers
    function cmd_is_read;
        input [3:0] c;
        begin
            cmd_is_read = (c == `DWSS_CMD_READ) || (c == `DWSS_CMD_MS_RD) ||
                (c == `DWSS_CMD_NV_RD) || (c == `DWSS_CMD_USB_ST);
        end
    endfunction

    function cmd_is_write;
        input [3:0] c;
        begin
            cmd_is_write = (c == `DWSS_CMD_WRITE) || (c == `DWSS_CMD_MS_WR) ||
                (c == `DWSS_CMD_NV_ADDR) || (c == `DWSS_CMD_NV_WR);
        end
    endfunction

    // Beats per byte minus one
    function [3:0] last_beat;
        input [1:0] w;
        begin
            last_beat = (4'h8 >> w) - 4'h1;
        end
    endfunction

    // Pin synchroniser
    dwss_sync #(
        .WIDTH(10)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({sclk, cs_n, bidir_data_lines_in}),
        .sync_out(pins_s)
    );

    // Lane shifter
    dwss_shift u_shift (
        .mclk(mclk),
        .rst(rst),
        .load(load),
        .load_byte(load_byte),
        .sample(sample),
        .advance(advance),
        .width(width),
        .lsb_first(lsb_first),
        .lines_in(lines_s),
        .rx_byte(rx_byte),
        .tx_lanes(tx_lanes)
    );

    // Byte to return for the current read command
    always @* begin
        case (cmd)
            `DWSS_CMD_READ: load_byte = rd_data;
            `DWSS_CMD_MS_RD: load_byte = {6'h00, modem_dtr, modem_rts}; // R3
            `DWSS_CMD_NV_RD: load_byte = nv_rdata; // R8
            `DWSS_CMD_USB_ST: load_byte = {6'h00, usb_state}; // R9
            default: load_byte = `DWSS_BYTE_RST;
        endcase
    end

    // Per-byte ready flag
    wire byte_ok = (cmd == `DWSS_CMD_READ) ? rd_valid :
        (cmd == `DWSS_CMD_WRITE) ? wr_space : 1'b1;

    // Main sequencer; rate-independent, edges only (R17)
    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            cpol <= 1'b0;
            lsb_first <= 1'b0;
            sclk_d <= 1'b0;
            width <= `DWSS_W1;
            cmd <= `DWSS_CMD_WRITE;
            edge_odd <= 1'b1;
            beats <= 4'h0;
            load <= 1'b0;
            sample <= 1'b0;
            advance <= 1'b0;
            bidir_data_lines_out <= `DWSS_LINES_IDLE;
            bidir_data_lines_oe <= 8'h00;
            miso <= `DWSS_NAK;
            rd_pop <= 1'b0;
            wr_push <= 1'b0;
            wr_data <= `DWSS_BYTE_RST;
            modem_status <= 4'h0;
            flush_req <= 1'b0;
            nv_addr <= `DWSS_NV_ADDR_RST;
            nv_we <= 1'b0;
            nv_wdata <= `DWSS_BYTE_RST;
        end else begin
            sclk_d <= sclk_s;
            load <= 1'b0;
            sample <= 1'b0;
            advance <= 1'b0;
            rd_pop <= 1'b0;
            wr_push <= 1'b0;
            flush_req <= 1'b0;
            nv_we <= 1'b0;
            if (cs_n_s) begin
                // Idle: show buffer status, take config (R22)
                state <= ST_IDLE;
                cpol <= cfg_cpol; // R22
                lsb_first <= cfg_lsb_first; // R10
                edge_odd <= 1'b1;
                sclk_d <= cfg_cpol;
                bidir_data_lines_oe <= 8'h01; // R16
                bidir_data_lines_out <= {7'h7F, wr_space}; // R20
                miso <= rd_valid; // R20
            end else begin
                case (state)
                    ST_IDLE: begin
                        // Turnaround: release lines (R16)
                        bidir_data_lines_oe <= 8'h00;
                        miso <= `DWSS_ACK;
                        state <= ST_CMD;
                    end
                    ST_CMD: begin
                        if (any_edge) begin
                            edge_odd <= ~edge_odd;
                            if (edge_odd) begin
                                // First edge: width from lines (R18)
                                if (!(&lines_s[7:4])) width <= `DWSS_W8;
                                else if (!(&lines_s[3:2])) width <= `DWSS_W4;
                                else if (!lines_s[1]) width <= `DWSS_W2;
                                else width <= `DWSS_W1;
                            end else begin
                                // Second edge: sample command (R11, R15, R21)
                                cmd <= {lines_s[`DWSS_POS_C3], lines_s[`DWSS_POS_C2],
                                    lines_s[`DWSS_POS_C1], lines_s[`DWSS_POS_C0]}; // R1
                                beats <= 4'h0;
                                state <= ST_DATA;
                                load <= 1'b1;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (any_edge) begin
                            edge_odd <= ~edge_odd;
                            if (edge_odd) begin
                                // Drive edge (R14)
                                miso <= byte_ok ? `DWSS_ACK : `DWSS_NAK; // R19
                                if (cmd_is_read(cmd) && byte_ok) begin
                                    bidir_data_lines_oe <= 8'hFF;
                                    bidir_data_lines_out <= tx_lanes;
                                    advance <= 1'b1;
                                end else begin
                                    bidir_data_lines_oe <= 8'h00;
                                end
                            end else begin
                                // Sample edge (R15)
                                if (cmd_is_write(cmd)) sample <= 1'b1;
                                if (beats == last_beat(width)) begin
                                    beats <= 4'h0;
                                    state <= ST_DONE;
                                end else begin
                                    beats <= beats + 4'h1;
                                end
                            end
                        end
                        if (cmd == `DWSS_CMD_FLUSH || cmd >= `DWSS_CMD_FIRST_RSV) begin
                            // Flush pulses once; reserved are no-ops (R2)
                            if (cmd == `DWSS_CMD_FLUSH) flush_req <= 1'b1; // R5
                            state <= ST_DONE;
                            beats <= 4'hF;
                        end
                    end
                    ST_DONE: begin
                        // Byte complete: commit once the shifter has taken the last beat
                        if (beats != 4'hF && !sample) begin
                            case (cmd)
                                `DWSS_CMD_WRITE: begin
                                    wr_push <= byte_ok;
                                    wr_data <= rx_byte;
                                end
                                `DWSS_CMD_READ: rd_pop <= byte_ok;
                                `DWSS_CMD_MS_WR: modem_status <= rx_byte[3:0]; // R4
                                `DWSS_CMD_NV_ADDR: nv_addr <= rx_byte; // R6
                                `DWSS_CMD_NV_WR: begin
                                    nv_we <= 1'b1; // R7
                                    nv_wdata <= rx_byte;
                                end
                                default: begin
                                end
                            endcase
                            state <= ST_DATA;
                            load <= 1'b1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ---- hw/dwss_sync.v ----
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module dwss_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    // First stage, read only by second stage
    reg [WIDTH-1:0] meta;

    // Two stage capture
    always @(posedge mclk) begin
        if (rst) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- test/dwss_master.sv ----
`timescale 1ns/100ps
// Bus master model: select, clock and lines
module dwss_master (
    // Clock and settings
    input wire logic mclk,
    input wire logic cpol,
    // Link pins
    input wire logic [7:0] lines,
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic [7:0] m_out,
    output logic [7:0] m_oe
);
    logic ph = 1'b0; // Clock away from idle
    logic [7:0] tx [4]; // Bytes to send
    logic [7:0] rx [4]; // Bytes read back
    logic ack [4]; // Status per byte
    // Same polarity as the slave, phase 1 only
    assign sclk = cpol ^ ph;
    initial begin
        cs_n = 1'b1;
        m_out = 8'hFF;
        m_oe = 8'h00;
    end
    // Half of the 800 ns link period
    task automatic half;
        repeat (4) @(negedge mclk);
    endtask
    // One frame: command byte, then n bytes
    task automatic xfer(input logic [3:0] c, input logic [1:0] w, input logic lf,
        input int n, input logic rd);
        int b, k, j, wd;
        logic [7:0] cb;
        wd = 1 << w;
        cb = {1'b1, c[0], c[1], 1'b1, c[2], 1'b1, 1'b1, c[3]};
        if (w != 2'h0) cb[w == 2'h3 ? 3'h4 : {1'b0, w}] = 1'b0;
        @(negedge mclk);
        cs_n = 1'b0;
        half();
        ph = 1'b1; // Edge 1: master takes the lines
        m_oe = 8'hFF;
        m_out = cb;
        half();
        ph = 1'b0; // Edge 2: command taken
        half();
        for (b = 0; b < n; b++) begin
            for (k = 0; k < 8 / wd; k++) begin
                ph = 1'b1; // Odd edge: next lanes
                m_oe = rd ? 8'h00 : 8'((9'h001 << wd) - 9'h001);
                for (j = 0; j < wd; j++) m_out[j] = tx[b][lf ? k*wd+j : 7-(k*wd+j)];
                half();
                ph = 1'b0; // Even edge: sample
                half();
                for (j = 0; j < wd; j++) rx[b][lf ? k*wd+j : 7-(k*wd+j)] = lines[j];
                if (k == 0) ack[b] = miso;
            end
            if (ack[b] === 1'b1) b = n; // Refused byte ends the frame
        end
        half();
        cs_n = 1'b1; // Close and release
        m_oe = 8'h00;
        half();
    endtask
endmodule

// ---- test/dwss_slave_monitor.sv ----
`timescale 1ns/100ps
// Port checks on the serial slave
module dwss_slave_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link pins
    input wire logic cs_n,
    input wire logic [7:0] bidir_data_lines_out,
    input wire logic [7:0] bidir_data_lines_oe,
    input wire logic miso,
    // Side ports
    input wire logic rd_valid,
    input wire logic rd_pop,
    input wire logic wr_space,
    input wire logic wr_push,
    input wire logic flush_req,
    input wire logic nv_we
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Idle with steady write space
    sequence idle_space_s;
        (cs_n && $stable(wr_space)) [*8];
    endsequence
    // Idle with steady read status
    sequence idle_avail_s;
        (cs_n && $stable(rd_valid)) [*8];
    endsequence
    // Select taken, before any device drive
    sequence open_s;
        $fell(cs_n) ##4 1'b1;
    endsequence
    reset_state_a: assert property ($fell(rst) |-> bidir_data_lines_oe == 8'h00 &&
        bidir_data_lines_out == 8'hFF && miso && !flush_req && !nv_we) else $error("reset state");
    idle_space_a: assert property (idle_space_s |-> bidir_data_lines_oe == 8'h01 &&
        bidir_data_lines_out[0] == wr_space) else $error("idle space line");
    idle_avail_a: assert property (idle_avail_s |-> miso == rd_valid)
        else $error("idle read status");
    turnaround_a: assert property (open_s |-> (bidir_data_lines_oe == 8'h00) [*3])
        else $error("lines not released");
    flush_pulse_a: assert property (flush_req |=> !flush_req)
        else $error("flush not one cycle");
    nv_pulse_a: assert property ($rose(nv_we) |=> !nv_we)
        else $error("memory write not one cycle");
    push_space_a: assert property (wr_push |-> wr_space ##1 !wr_push)
        else $error("push without space");
    pop_valid_a: assert property (rd_pop |-> rd_valid ##1 !rd_pop)
        else $error("pop without data");
endmodule
bind dwss_slave dwss_slave_monitor u_mon (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .bidir_data_lines_out(bidir_data_lines_out), .bidir_data_lines_oe(bidir_data_lines_oe),
    .miso(miso), .rd_valid(rd_valid), .rd_pop(rd_pop), .wr_space(wr_space),
    .wr_push(wr_push), .flush_req(flush_req), .nv_we(nv_we));

// ---- test/tb_dwss_slave.sv ----
`timescale 1ns/100ps
// Self-checking bench for the serial slave
module tb_dwss_slave;
    // One ordinary case
    typedef struct {
        logic [3:0] cmd;
        logic [1:0] w;
        logic cp;
        logic lf;
        logic [7:0] tx;
        logic [7:0] exp;
    } dwss_row_t;
    // Clock, reset, settings
    logic mclk, rst, cpol, lsbf;
    // Link wires
    logic sclk, cs_n, miso;
    logic [7:0] lines, d_out, d_oe, m_out, m_oe;
    // Side ports
    logic rd_valid, rd_pop, wr_space, wr_push, rts, dtr, flush, nv_we;
    logic [7:0] rd_data, wr_data, nv_addr, nv_wdata, nv_rdata;
    logic [3:0] ms;
    logic [1:0] usb_state;
    // Scoreboard
    int num_errors, compares, n_push, n_pop, n_flush, n_nv;
    logic [7:0] last_wr, last_nv;
    // Command, width, polarity, order, sent, expected
    dwss_row_t rows [11] = '{'{4'h0, 2'h3, 1'b0, 1'b1, 8'hC3, 8'hC3},
        '{4'h1, 2'h3, 1'b1, 1'b0, 8'h00, 8'h3C}, '{4'h2, 2'h3, 1'b0, 1'b0, 8'h00, 8'h01},
        '{4'h3, 2'h2, 1'b1, 1'b1, 8'h0A, 8'h0A}, '{4'h4, 2'h3, 1'b0, 1'b1, 8'h00, 8'h01},
        '{4'h5, 2'h3, 1'b1, 1'b1, 8'h21, 8'h21}, '{4'h6, 2'h3, 1'b0, 1'b0, 8'h44, 8'h44},
        '{4'h7, 2'h0, 1'b0, 1'b1, 8'h00, 8'h7B}, '{4'h7, 2'h1, 1'b1, 1'b0, 8'h00, 8'h7B},
        '{4'h8, 2'h3, 1'b1, 1'b0, 8'h00, 8'h02}, '{4'h0, 2'h3, 1'b1, 1'b0, 8'h81, 8'h81}};
    dwss_slave DUT (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .bidir_data_lines_in(lines), .bidir_data_lines_out(d_out),
        .bidir_data_lines_oe(d_oe), .miso(miso), .cfg_cpol(cpol), .cfg_lsb_first(lsbf),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_pop(rd_pop), .wr_space(wr_space),
        .wr_push(wr_push), .wr_data(wr_data), .modem_rts(rts), .modem_dtr(dtr),
        .modem_status(ms), .flush_req(flush), .nv_addr(nv_addr), .nv_we(nv_we),
        .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .usb_state(usb_state));
    dwss_master m (.mclk(mclk), .cpol(cpol), .lines(lines), .miso(miso), .sclk(sclk),
        .cs_n(cs_n), .m_out(m_out), .m_oe(m_oe));
    // Wire level: enabled driver, else pull-up
    assign lines = (d_oe & d_out) | (~d_oe & m_oe & m_out) | (~d_oe & ~m_oe);
    // Memory contents seen at an address
    assign nv_rdata = nv_addr ^ 8'h5A;
    // Count pulses and keep their data
    always @(posedge mclk) begin
        if (wr_push === 1'b1) last_wr = wr_data;
        if (nv_we === 1'b1) last_nv = nv_wdata;
        n_push += (wr_push === 1'b1);
        n_pop += (rd_pop === 1'b1);
        n_flush += (flush === 1'b1);
        n_nv += (nv_we === 1'b1);
    end
    // Byte compare
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Counts, verdict, end of run
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Settings while idle, then one frame
    task automatic frame(input logic [3:0] c, input logic [1:0] w, input logic cp,
        input logic lf, input logic [7:0] tx, input int n);
        cpol = cp;
        lsbf = lf;
        repeat (8) @(negedge mclk);
        {n_push, n_pop, n_flush, n_nv} = 128'h0;
        m.tx[0] = tx;
        m.xfer(c, w, lf, n, c == 4'h1 || c == 4'h2 || c == 4'h7 || c == 4'h8);
    endtask
    // Value that shows a command's effect
    function automatic logic [7:0] seen(input logic [3:0] c);
        case (c)
            4'h0: seen = last_wr;
            4'h3: seen = {4'h0, ms};
            4'h4: seen = 8'(n_flush);
            4'h5: seen = nv_addr;
            4'h6: seen = last_nv;
            default: seen = m.rx[0];
        endcase
    endfunction
    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #2000000;
        num_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        give_verdict();
    end
    // Main sequence
    initial begin
        {num_errors, compares} = 64'h0;
        {rst, cpol, lsbf, rd_valid, wr_space, rts, dtr} = 7'h4E;
        rd_data = 8'h3C;
        usb_state = 2'h2;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        foreach (rows[i]) begin
            frame(rows[i].cmd, rows[i].w, rows[i].cp, rows[i].lf, rows[i].tx, rows[i].cmd != 4'h4);
            chk8("row", rows[i].exp, seen(rows[i].cmd));
            if (rows[i].cmd != 4'h4) chk8("ack", 8'h00, {7'h0, m.ack[0]});
            $display("row %0d done", i);
        end
        for (int c = 9; c < 16; c++) begin
            frame(c[3:0], 2'h3, 1'b0, 1'b1, 8'h77, 1);
            chk8("reserved_pulses", 8'h00, 8'(n_push + n_pop + n_flush + n_nv));
            chk8("reserved_state", 8'h21, nv_addr ^ {4'h0, ms ^ 4'hA});
        end
        $display("reserved done");
        wr_space = 1'b0;
        frame(4'h0, 2'h3, 1'b0, 1'b1, 8'h55, 1);
        chk8("write_refused", 8'h01, {7'h0, m.ack[0]} | 8'(n_push));
        {wr_space, rd_valid} = 2'h2;
        frame(4'h1, 2'h3, 1'b0, 1'b1, 8'h00, 1);
        chk8("read_refused", 8'h01, {7'h0, m.ack[0]} | 8'(n_pop));
        for (int v = 0; v < 4; v++) begin
            {rd_valid, wr_space} = v[1:0];
            repeat (8) @(negedge mclk);
            chk8("idle_status", 8'(v), {6'h0, miso, lines[0]});
        end
        {rd_valid, wr_space} = 2'h3;
        $display("refusal and idle done");
        m.tx[1] = 8'h5E;
        m.tx[2] = 8'hA7;
        frame(4'h0, 2'h3, 1'b0, 1'b1, 8'h12, 3);
        chk8("push_count", 8'h03, 8'(n_push));
        chk8("last_push", 8'hA7, last_wr);
        fork
            frame(4'h0, 2'h3, 1'b0, 1'b1, 8'h99, 2);
            begin
                repeat (30) @(negedge mclk);
                rst = 1'b1;
                repeat (4) @(negedge mclk);
                chk8("reset_oe", 8'h00, d_oe);
                rst = 1'b0;
            end
        join
        frame(4'h0, 2'h3, 1'b0, 1'b1, 8'h6D, 1);
        chk8("after_reset", 8'h6D, last_wr);
        $display("burst and reset done");
        give_verdict();
    end
endmodule
